// [hdl/mdc_pkg.sv]
// Package for the four channel memory mover: register map, fields, sizes
// Assumes a single 50 MHz clock and a plain strobed register port
package mdc_pkg;
	// ****************************************************************
	// Sizes
	// ****************************************************************
	localparam int NCH = 4;
	localparam int NPER = 6;
	localparam int IDXW = 13;
	localparam int PRIW = 3;
	localparam int SELW = 3;
	localparam int AW = 8;
	// ****************************************************************
	// Register offsets (byte addresses)
	// ****************************************************************
	localparam logic [7:0] OFS_SRC = 8'h00;
	localparam logic [7:0] OFS_DST = 8'h04;
	localparam logic [7:0] OFS_LEN = 8'h08;
	localparam logic [7:0] OFS_MATCH = 8'h0C;
	localparam logic [7:0] OFS_CTRL = 8'h10;
	localparam logic [7:0] OFS_INDEX = 8'h14;
	localparam logic [7:0] CH_STRIDE = 8'h20;
	localparam logic [7:0] OFS_MUX = 8'h80;
	localparam logic [7:0] OFS_FRZ_SET = 8'h84;
	localparam logic [7:0] OFS_FRZ_CLR = 8'h88;
	localparam logic [7:0] OFS_STATUS = 8'h8C;
	// ****************************************************************
	// Control field positions
	// ****************************************************************
	localparam int B_ON = 0;
	localparam int B_REQ_MODE = 1;
	localparam int B_SRC_INC = 2;
	localparam int B_DST_INC = 3;
	localparam int B_WIDTH_LO = 4;
	localparam int B_WRAP = 6;
	localparam int B_IDLE = 7;
	localparam int B_INIT = 8;
	localparam int B_PRIO_LO = 9;
	localparam int CTRL_W = 12;
	localparam logic [CTRL_W-1:0] CTRL_RST = 12'h000;
	// Item width codes
	localparam logic [1:0] W_BYTE = 2'h0;
	localparam logic [1:0] W_HALF = 2'h1;
	localparam logic [1:0] W_WORD = 2'h2;
	// Selector value meaning no connection
	localparam logic [SELW-1:0] SEL_NONE = 3'h7;
	localparam logic [31:0] MUX_RST = 32'h0000_7777;
endpackage

// [hdl/mdc_dma.sv]
// Four channel DMA engine with request multiplexer, arbitration, freeze
// Assumes one clock domain; memory bus answers with a one-cycle ready pulse
//
// Contract
// R1 - Four independent channels with 32-bit pointers and optional trigger.
// R2 - Separate receive and transmit requests from six peripherals accepted.
// R3 - Pair selector routes receive to channel x, transmit to channel y.
// R4 - Acknowledges go back to the selected peripheral, mirroring requests.
// R5 - Equal selector values: the less significant selector wins.
// R6 - Channel runs while on bit set; bit clears when transfer finishes.
// R7 - Request mode 0 starts at once; 1 waits for peripheral request.
// R8 - Each item moves one 8, 16 or 32-bit word source to destination.
// R9 - 13-bit index cleared at start, compared with length after each item.
// R10 - Address is start plus index scaled by increment bit and width.
// R11 - Continue while start holds; stop if request mode low or index=length.
// R12 - Wrap mode restarts index; immediate mode always stops.
// R13 - Interrupt when match equals index, after item, before increment.
// R14 - Length 0 moves one item; match 0 then also interrupts.
// R15 - Highest 3-bit priority wins arbitration; fixed order breaks ties.
// R16 - Immediate-mode channel yields to higher priority only with idle bit.
// R17 - Init bit locks the bus until the whole transfer completes.
// R18 - Software uses init only for memory fill, source fixed, dest stepping.
// R19 - Freeze-set bit suspends a channel; freeze-clear bit releases it.
// R20 - Running memory-to-memory transfer finishes before freeze applies.
// R21 - Programming values are used as written, without checks.
// R22 - Equal priorities: lowest-numbered channel granted first.
// R23 - Item is one read then one write; grant held for the item.
//
// Added by the designer: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps
module mdc_dma (
	// Clock and reset
	input wire logic clock,
	input wire logic srst,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// Peripheral requests, bit 2p receive, 2p+1 transmit
	input wire logic [2*mdc_pkg::NPER-1:0] periph_req,
	output logic [2*mdc_pkg::NPER-1:0] periph_ack,
	// Memory bus master
	output logic mem_valid,
	output logic mem_write,
	output logic [31:0] mem_addr,
	output logic [1:0] mem_size,
	output logic [31:0] mem_wdata,
	input wire logic mem_ready,
	input wire logic [31:0] mem_rdata,
	// Channel events
	output logic [mdc_pkg::NCH-1:0] chan_irq
);
	localparam int N = mdc_pkg::NCH;
	localparam int IW = mdc_pkg::IDXW;
	localparam int PW = mdc_pkg::PRIW;

	typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE} mdc_state_t;

	// ****************************************************************
	// Functions
	// ****************************************************************
	// Scaled index: byte offset of item, zero when not stepping
	function automatic logic [31:0] mdc_offset(input logic inc,
		input logic [1:0] w, input logic [IW-1:0] idx);
		logic [31:0] o;
		o = {19'h0, idx};
		if (!inc)
			mdc_offset = 32'h0;
		else if (w == mdc_pkg::W_WORD)
			mdc_offset = {o[29:0], 2'h0};
		else if (w == mdc_pkg::W_HALF)
			mdc_offset = {o[30:0], 1'h0};
		else
			mdc_offset = o;
	endfunction

	// Byte address decode of a channel register
	function automatic logic mdc_hit(input logic [7:0] a, input int ch,
		input logic [7:0] ofs);
		mdc_hit = (a == 8'((ch * mdc_pkg::CH_STRIDE) + ofs));
	endfunction

	// ****************************************************************
	// Registers
	// ****************************************************************
	logic [31:0] src_q [N];
	logic [31:0] dst_q [N];
	logic [IW-1:0] len_q [N];
	logic [IW-1:0] match_q [N];
	logic [mdc_pkg::CTRL_W-1:0] ctrl_q [N];
	logic [IW-1:0] idx_q [N];
	logic [31:0] mux_q;
	logic [N-1:0] frz_q;
	logic [N-1:0] req_line;
	logic [N-1:0] want;
	logic [N-1:0] done_pulse;
	mdc_state_t state_q;
	logic [1:0] act_q;
	logic [31:0] data_q;
	logic [1:0] win;
	logic win_ok;
	logic [N-1:0] ack_ch;
	logic item_end;

	// ****************************************************************
	// Request multiplexer
	// ****************************************************************
	// Pair k feeds channel 2k (receive) and 2k+1 (transmit)
	always_comb
	begin
		req_line = '0;
		periph_ack = '0;
		for (int k = 0; k < N / 2; k++)
		begin
			logic [2:0] s;
			logic taken;
			s = mux_q[4*k +: 3];
			taken = 1'b0;
			// A lower selector holding the same value keeps the link
			for (int j = 0; j < k; j++)
				if (mux_q[4*j +: 3] == s) taken = 1'b1; // R5
			if (s < 3'(mdc_pkg::NPER) && !taken)
			begin
				req_line[2*k] = periph_req[2*s]; // R2 R3
				req_line[2*k+1] = periph_req[2*s+1]; // R3
				periph_ack[2*s] = ack_ch[2*k]; // R4
				periph_ack[2*s+1] = ack_ch[2*k+1]; // R4
			end
		end
	end

	// ****************************************************************
	// Arbitration
	// ****************************************************************
	// A channel wants service when on, not frozen, and triggered
	always_comb
	begin
		// A started memory copy ignores freeze until it ends
		for (int c = 0; c < N; c++)
			want[c] = ctrl_q[c][mdc_pkg::B_ON] && (!frz_q[c] ||
				(!ctrl_q[c][mdc_pkg::B_REQ_MODE] && idx_q[c] != '0)) &&
				(!ctrl_q[c][mdc_pkg::B_REQ_MODE] || req_line[c]); // R6 R7 R20
	end

	// Highest priority wins, lower number first on a tie
	always_comb
	begin
		logic [PW-1:0] best;
		best = '0;
		win = 2'h0;
		win_ok = 1'b0;
		for (int c = 0; c < N; c++)
			if (want[c] && (!win_ok ||
				ctrl_q[c][mdc_pkg::B_PRIO_LO +: PW] > best)) // R15 R22
			begin
				best = ctrl_q[c][mdc_pkg::B_PRIO_LO +: PW];
				win = 2'(c);
				win_ok = 1'b1;
			end
	end

	// ****************************************************************
	// Item engine
	// ****************************************************************
	assign item_end = (state_q == ST_WRITE) && mem_ready;
	// Ack pulses with the completed write of a triggered item
	always_comb
	begin
		ack_ch = '0;
		if (item_end && ctrl_q[act_q][mdc_pkg::B_REQ_MODE])
			ack_ch[act_q] = 1'b1; // R4
	end

	// Current owner keeps the bus unless pre-emption is allowed
	function automatic logic mdc_keep(input logic [1:0] a);
		logic imm;
		imm = !ctrl_q[a][mdc_pkg::B_REQ_MODE];
		if (ctrl_q[a][mdc_pkg::B_INIT])
			mdc_keep = 1'b1; // R17
		else if (imm && !ctrl_q[a][mdc_pkg::B_IDLE])
			mdc_keep = 1'b1; // R16 R20
		else
			mdc_keep = 1'b0;
	endfunction

	// Read then write per item, owner chosen between items
	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			state_q <= ST_IDLE;
			act_q <= 2'h0;
			data_q <= 32'h0;
		end
		else
		begin
			unique case (state_q)
				ST_IDLE:
				begin
					if (want[act_q] && ctrl_q[act_q][mdc_pkg::B_ON] &&
						mdc_keep(act_q) && idx_q[act_q] != '0)
						state_q <= ST_READ; // R17 R20
					else if (win_ok)
					begin
						act_q <= win;
						state_q <= ST_READ;
					end
				end
				ST_READ:
					if (mem_ready)
					begin
						data_q <= mem_rdata; // R23
						state_q <= ST_WRITE;
					end
				ST_WRITE:
					if (mem_ready)
						state_q <= ST_IDLE; // R23
			endcase
		end
	end

	// Memory bus outputs
	always_comb
	begin
		logic [31:0] so;
		logic [31:0] dofs;
		so = mdc_offset(ctrl_q[act_q][mdc_pkg::B_SRC_INC],
			ctrl_q[act_q][mdc_pkg::B_WIDTH_LO +: 2], idx_q[act_q]);
		dofs = mdc_offset(ctrl_q[act_q][mdc_pkg::B_DST_INC],
			ctrl_q[act_q][mdc_pkg::B_WIDTH_LO +: 2], idx_q[act_q]);
		mem_valid = (state_q != ST_IDLE);
		mem_write = (state_q == ST_WRITE);
		mem_size = ctrl_q[act_q][mdc_pkg::B_WIDTH_LO +: 2]; // R8
		mem_wdata = data_q;
		if (state_q == ST_WRITE)
			mem_addr = dst_q[act_q] + dofs; // R10
		else
			mem_addr = src_q[act_q] + so; // R10
	end

	// ****************************************************************
	// Channel state: index, on bit, events
	// ****************************************************************
	always_comb
	begin
		done_pulse = '0;
		if (item_end && idx_q[act_q] == len_q[act_q])
			done_pulse[act_q] = 1'b1; // R11 R14
	end

	// Match event after the item, with the index still unchanged
	always_ff @(posedge clock)
	begin
		if (srst)
			chan_irq <= '0;
		else
			for (int c = 0; c < N; c++)
				chan_irq[c] <= item_end && act_q == 2'(c) &&
					match_q[c] == idx_q[c]; // R13 R14
	end

	// Register writes, index stepping and on-bit auto clear
	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			for (int c = 0; c < N; c++)
			begin
				src_q[c] <= 32'h0;
				dst_q[c] <= 32'h0;
				len_q[c] <= '0;
				match_q[c] <= '0;
				ctrl_q[c] <= mdc_pkg::CTRL_RST;
				idx_q[c] <= '0;
			end
		end
		else
		begin
			for (int c = 0; c < N; c++)
			begin
				// Values stored as written, no consistency checks
				if (reg_wr && mdc_hit(reg_addr, c, mdc_pkg::OFS_SRC))
					src_q[c] <= reg_wdata; // R1 R21
				if (reg_wr && mdc_hit(reg_addr, c, mdc_pkg::OFS_DST))
					dst_q[c] <= reg_wdata; // R1 R21
				if (reg_wr && mdc_hit(reg_addr, c, mdc_pkg::OFS_LEN))
					len_q[c] <= reg_wdata[IW-1:0];
				if (reg_wr && mdc_hit(reg_addr, c, mdc_pkg::OFS_MATCH))
					match_q[c] <= reg_wdata[IW-1:0];
				if (reg_wr && mdc_hit(reg_addr, c, mdc_pkg::OFS_CTRL))
				begin
					ctrl_q[c] <= reg_wdata[mdc_pkg::CTRL_W-1:0];
					if (reg_wdata[mdc_pkg::B_ON] && !ctrl_q[c][mdc_pkg::B_ON])
						idx_q[c] <= '0; // R9
				end
				else if (done_pulse[c])
				begin
					idx_q[c] <= '0;
					// Triggered wrap mode restarts, otherwise the channel ends
					if (!ctrl_q[c][mdc_pkg::B_REQ_MODE] ||
						!ctrl_q[c][mdc_pkg::B_WRAP])
						ctrl_q[c][mdc_pkg::B_ON] <= 1'b0; // R6 R11 R12
				end
				else if (item_end && act_q == 2'(c))
					idx_q[c] <= idx_q[c] + 1'b1; // R9
			end
		end
	end

	// Multiplexer and freeze registers
	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			mux_q <= mdc_pkg::MUX_RST;
			frz_q <= '0;
		end
		else
		begin
			if (reg_wr && reg_addr == mdc_pkg::OFS_MUX)
				mux_q <= reg_wdata;
			// Running memory copies finish first, see the want logic
			if (reg_wr && reg_addr == mdc_pkg::OFS_FRZ_SET)
				frz_q <= frz_q | reg_wdata[N-1:0]; // R19
			else if (reg_wr && reg_addr == mdc_pkg::OFS_FRZ_CLR)
				frz_q <= frz_q & ~reg_wdata[N-1:0]; // R19
		end
	end

	// Read data, one cycle after the strobe; unmapped reads zero
	always_ff @(posedge clock)
	begin
		if (srst)
			reg_rdata <= 32'h0;
		else
		begin
			reg_rdata <= 32'h0;
			if (reg_rd)
			begin
				for (int c = 0; c < N; c++)
				begin
					if (mdc_hit(reg_addr, c, mdc_pkg::OFS_SRC))
						reg_rdata <= src_q[c];
					if (mdc_hit(reg_addr, c, mdc_pkg::OFS_DST))
						reg_rdata <= dst_q[c];
					if (mdc_hit(reg_addr, c, mdc_pkg::OFS_LEN))
						reg_rdata <= {19'h0, len_q[c]};
					if (mdc_hit(reg_addr, c, mdc_pkg::OFS_MATCH))
						reg_rdata <= {19'h0, match_q[c]};
					if (mdc_hit(reg_addr, c, mdc_pkg::OFS_CTRL))
						reg_rdata <= {20'h0, ctrl_q[c]};
					if (mdc_hit(reg_addr, c, mdc_pkg::OFS_INDEX))
						reg_rdata <= {19'h0, idx_q[c]};
				end
				if (reg_addr == mdc_pkg::OFS_MUX)
					reg_rdata <= mux_q;
				if (reg_addr == mdc_pkg::OFS_STATUS)
					reg_rdata <= {28'h0, frz_q};
			end
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	// Read phase that completed, then the write carrying its data
	sequence s_read_done;
		state_q == ST_READ && mem_ready;
	endsequence
	sequence s_write_next;
		mem_valid && mem_write && mem_wdata == $past(mem_rdata);
	endsequence

	a_item_order: assert property (@(posedge clock) disable iff (srst) // R23
		s_read_done |=> s_write_next)
		else $error("read not followed by write");
	a_write_held: assert property (@(posedge clock) disable iff (srst) // R23
		(state_q == ST_WRITE && !mem_ready) |=> state_q == ST_WRITE)
		else $error("write dropped early");
	a_done_clears: assert property (@(posedge clock) disable iff (srst) // R6 R11
		(done_pulse[0] && !ctrl_q[0][mdc_pkg::B_REQ_MODE] && !reg_wr)
		|=> !ctrl_q[0][mdc_pkg::B_ON])
		else $error("on bit not cleared");
	a_wrap_keeps: assert property (@(posedge clock) disable iff (srst) // R12
		(done_pulse[0] && ctrl_q[0][mdc_pkg::B_REQ_MODE] &&
		ctrl_q[0][mdc_pkg::B_WRAP] && !reg_wr)
		|=> ctrl_q[0][mdc_pkg::B_ON] && idx_q[0] == '0)
		else $error("wrap did not restart");
	a_match_irq: assert property (@(posedge clock) disable iff (srst) // R13
		(item_end && act_q == 2'h0 && match_q[0] == idx_q[0])
		|=> chan_irq[0])
		else $error("match event missing");
	a_idx_step: assert property (@(posedge clock) disable iff (srst) // R9
		(item_end && act_q == 2'h2 && !done_pulse[2] && !reg_wr)
		|=> idx_q[2] == $past(idx_q[2]) + 1'b1)
		else $error("index did not step");
	a_frozen_idle: assert property (@(posedge clock) disable iff (srst) // R19
		(state_q == ST_IDLE && frz_q[3] && act_q != 2'h3 &&
		(ctrl_q[3][mdc_pkg::B_REQ_MODE] || idx_q[3] == '0))
		|=> !(state_q == ST_READ && act_q == 2'h3))
		else $error("frozen channel started");
	a_init_lock: assert property (@(posedge clock) disable iff (srst) // R17
		(item_end && ctrl_q[act_q][mdc_pkg::B_INIT] &&
		ctrl_q[act_q][mdc_pkg::B_ON] && !done_pulse[act_q] && !reg_wr &&
		want[act_q]) |=> ##1 act_q == $past(act_q, 2))
		else $error("locked channel pre-empted");
	a_prio_win: assert property (@(posedge clock) disable iff (srst) // R15
		(want[0] && want[1] && ctrl_q[1][mdc_pkg::B_PRIO_LO +: PW] >
		ctrl_q[0][mdc_pkg::B_PRIO_LO +: PW]) |-> win != 2'h0)
		else $error("lower priority won");
	a_mux_route: assert property (@(posedge clock) disable iff (srst) // R3
		(mux_q[2:0] == 3'h3) |-> req_line[0] == periph_req[6])
		else $error("receive request misrouted");
endmodule

// [tb/mdc_mem_model.sv]
// Memory slave model facing the DMA engine's memory bus
// Assumes the master holds valid, phase and address until ready
`timescale 1ns/100ps
module mdc_mem_model (
	// Clock and reset
	input wire logic clock,
	input wire logic srst,
	// Memory bus, slave side
	input wire logic mem_valid,
	input wire logic mem_write,
	input wire logic [31:0] mem_addr,
	output logic mem_ready,
	output logic [31:0] mem_rdata,
	// Wait states before each ready
	input wire logic [3:0] wait_cycles
);
	logic [3:0] cnt_q;
	logic [31:0] last_q;
	// Count wait states of the current phase
	always_ff @(posedge clock)
	begin
		if (srst || !mem_valid || mem_ready)
			cnt_q <= 4'h0;
		else
			cnt_q <= cnt_q + 4'h1;
	end
	// One ready per phase: read answered, then write answered
	assign mem_ready = mem_valid && !srst && cnt_q == wait_cycles;
	// Read data only with ready; otherwise a changing pattern
	assign mem_rdata = (mem_ready && !mem_write) ? ~mem_addr : ~last_q;
	always_ff @(posedge clock)
	begin
		last_q <= srst ? 32'h0 : mem_rdata;
	end
endmodule

// [tb/test_mdc_dma.sv]
// Self-checking bench for the four channel DMA engine
// Assumes the memory model as far side and bench-driven requests
`timescale 1ns/100ps
module test_mdc_dma;
	typedef struct packed {
		logic [1:0] c;
		logic [1:0] w;
		logic si;
		logic di;
		logic wrap;
		logic [12:0] len;
		logic [12:0] m;
		logic [3:0] lat;
		logic [1:0] nirq;
	} mdc_row_t;
	logic clock = 1'b0;
	logic srst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic [11:0] periph_req = 12'h000;
	logic [11:0] periph_ack;
	logic mem_valid, mem_write, mem_ready;
	logic [31:0] mem_addr, mem_wdata, mem_rdata;
	logic [1:0] mem_size;
	logic [3:0] chan_irq;
	logic [3:0] wait_cycles = 4'h0;
	int error_cnt = 0;
	int comparisons = 0;
	int irq_n, ack_n, ack_x;
	logic [31:0] wa_q[$], wd_q[$], src_q[$];
	logic [1:0] ws_q[$];
	logic [31:0] rv, sa, da, sx, dx, cw;
	mdc_row_t r;
	mdc_row_t rows[4] = '{
		'{2'h0, 2'h2, 1'b1, 1'b1, 1'b0, 13'h3, 13'h2, 4'h0, 2'h1},
		'{2'h1, 2'h0, 1'b0, 1'b1, 1'b0, 13'h0, 13'h0, 4'h3, 2'h1},
		'{2'h2, 2'h1, 1'b1, 1'b0, 1'b0, 13'h2, 13'h5, 4'h1, 2'h0},
		'{2'h3, 2'h2, 1'b1, 1'b1, 1'b1, 13'h1, 13'h1, 4'h2, 2'h1}
	};
	mdc_dma u_mdc_dma (.clock, .srst, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .periph_req, .periph_ack, .mem_valid,
		.mem_write, .mem_addr, .mem_size, .mem_wdata, .mem_ready,
		.mem_rdata, .chan_irq);
	mdc_mem_model u_mdc_mem_model (.clock, .srst, .mem_valid, .mem_write,
		.mem_addr, .mem_ready, .mem_rdata, .wait_cycles);
	// Clock of 20 ns
	always #10 clock = ~clock;
	// ****************************************************************
	// Bus monitor
	// ****************************************************************
	always @(posedge clock)
	begin
		if (mem_valid === 1'b1 && mem_ready === 1'b1)
		begin
			if (mem_write === 1'b1)
			begin
				wa_q.push_back(mem_addr);
				ws_q.push_back(mem_size);
				wd_q.push_back(mem_wdata);
			end
			else
				src_q.push_back(mem_addr);
		end
		irq_n += $countones(chan_irq);
		ack_n += int'(periph_ack[6]);
		ack_x += $countones(periph_ack & 12'hFBF);
	end
	// ****************************************************************
	// Tasks
	// ****************************************************************
	task automatic tally_and_finish();
		$display("errors %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic ok, input string msg);
		comparisons++;
		if (ok !== 1'b1)
		begin
			error_cnt++;
			$display("unexpected at %0t: %s", $time, msg);
		end
	endtask
	task automatic clr();
		wa_q.delete();
		wd_q.delete();
		ws_q.delete();
		src_q.delete();
		irq_n = 0;
		ack_n = 0;
		ack_x = 0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		@(negedge clock);
		rv = reg_rdata;
	endtask
	function automatic logic [31:0] ctl(input logic rm, si, di, wrap,
		input logic [1:0] w, input logic [2:0] p);
		return {20'h0, p, 2'h0, wrap, w, di, si, rm, 1'b1};
	endfunction
	task automatic prog(input int c, input logic [31:0] s, d,
		input logic [12:0] len, m, input logic [31:0] w);
		logic [7:0] b;
		b = 8'(c * 32);
		wr(b, s);
		wr(b + 8'h04, d);
		wr(b + 8'h08, {19'h0, len});
		wr(b + 8'h0C, {19'h0, m});
		wr(b + 8'h10, w);
	endtask
	task automatic wait_wr(input int n);
		int t;
		t = 0;
		while (wa_q.size() < n && t < 3000)
		begin
			@(posedge clock);
			t++;
		end
		if (wa_q.size() < n)
		begin
			error_cnt++;
			$display("unexpected at %0t: transfer hung", $time);
			tally_and_finish();
		end
	endtask
	// Two channels released together by one freeze-clear write
	task automatic race(input logic [2:0] p1, p3, input logic [31:0] f);
		clr();
		wr(8'h84, 32'hA);
		prog(1, 32'h4000, 32'h4100, 13'h0, 13'h1FFF, ctl(0, 1, 1, 0, 2'h2, p1));
		prog(3, 32'h4000, 32'h4300, 13'h0, 13'h1FFF, ctl(0, 1, 1, 0, 2'h2, p3));
		repeat (20) @(posedge clock);
		rd(8'h8C);
		chk(wa_q.size() == 0 && rv[3:0] === 4'hA, "frozen channel moved");
		wr(8'h88, 32'hA);
		wait_wr(2);
		chk(wa_q[0] === f && wa_q[1] !== f, "grant order");
	endtask
	// Urgent channel released in mid-copy: locked or yielding owner
	task automatic lock(input logic [31:0] x, input logic [31:0] last);
		clr();
		wr(8'h84, 32'h2);
		prog(1, 32'h6000, 32'h6800, 13'h0, 13'h1FFF, ctl(0, 1, 1, 0, 2'h2, 3'h7));
		prog(0, 32'h6000, 32'h6400, 13'h7, 13'h1FFF,
			ctl(0, 0, 1, 0, 2'h2, 3'h0) | x);
		wait_wr(1);
		wr(8'h88, 32'h2);
		wait_wr(9);
		chk(wa_q[8] === last, "pre-emption order");
	endtask
	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial
	begin
		clr();
		repeat (3) @(posedge clock);
		srst <= 1'b0;
		rd(8'h80);
		chk(rv === mdc_pkg::MUX_RST, "selector reset value");
		rd(8'h10);
		chk(rv === 32'h0, "control reset value");
		rd(8'h90);
		chk(rv === 32'h0, "unmapped read");
		foreach (rows[i])
		begin
			r = rows[i];
			clr();
			wait_cycles <= r.lat;
			sa = 32'h1000 + 32'(i) * 32'h100;
			da = sa + 32'h80;
			cw = ctl(1'b0, r.si, r.di, r.wrap, r.w, 3'h0);
			prog(r.c, sa, da, r.len, r.m, cw);
			wait_wr(int'(r.len) + 1);
			repeat (30) @(posedge clock);
			chk(wa_q.size() == int'(r.len) + 1, "item count");
			chk(irq_n == int'(r.nirq), "event count");
			for (int k = 0; k <= int'(r.len); k++)
			begin
				sx = sa + (r.si ? 32'(k) << r.w : 32'h0);
				dx = da + (r.di ? 32'(k) << r.w : 32'h0);
				chk(src_q[k] === sx && wa_q[k] === dx, "item address");
				chk(ws_q[k] === r.w, "item size");
				if (r.w == 2'h2)
					chk(wd_q[k] === ~sx, "item data");
			end
			rd(8'(r.c * 32) + 8'h10);
			chk(rv === (cw & 32'hFFFF_FFFE), "on bit left set");
		end
		// Both pairs pick the same peripheral; peripheral engines ch0 only
		clr();
		wait_cycles <= 4'h1;
		wr(8'h80, 32'h0000_7733);
		prog(2, 32'h3000, 32'h3800, 13'h0, 13'h1FFF, ctl(1, 1, 0, 0, 2'h2, 3'h0));
		prog(0, 32'h3000, 32'h3400, 13'h1, 13'h1FFF, ctl(1, 1, 1, 0, 2'h2, 3'h0));
		repeat (20) @(posedge clock);
		chk(wa_q.size() == 0, "ran without request");
		periph_req[6] <= 1'b1;
		wait_wr(2);
		repeat (30) @(posedge clock);
		chk(wa_q.size() == 2 && wa_q[1] === 32'h3404, "triggered run");
		chk(ack_n == 2 && ack_x == 0, "acknowledge routing");
		// Wrap mode restarts from the start addresses while requested
		clr();
		prog(0, 32'h3000, 32'h3400, 13'h1, 13'h1FFF, ctl(1, 1, 1, 1, 2'h2, 3'h0));
		wait_wr(5);
		chk(wa_q[3] === 32'h3404 && wa_q[4] === 32'h3400, "wrap restart");
		wr(8'h10, 32'h0);
		periph_req[6] <= 1'b0;
		repeat (20) @(posedge clock);
		race(3'h2, 3'h5, 32'h4300);
		race(3'h4, 3'h4, 32'h4100);
		// Freeze during a running memory copy waits for its end
		clr();
		prog(0, 32'h5000, 32'h5400, 13'h7, 13'h1FFF, ctl(0, 1, 1, 0, 2'h2, 3'h0));
		wait_wr(1);
		wr(8'h84, 32'h1);
		wait_wr(8);
		wr(8'h88, 32'h1);
		chk(wa_q[7] === 32'h541C, "copy cut by freeze");
		lock(32'h180, 32'h6800);
		lock(32'h080, 32'h641C);
		// Reset with no channel running puts selector and control back
		wr(8'h80, 32'h0000_0012);
		wr(8'h30, 32'h0000_0E00);
		srst <= 1'b1;
		repeat (3) @(posedge clock);
		srst <= 1'b0;
		rd(8'h80);
		chk(rv === mdc_pkg::MUX_RST, "selector after reset");
		rd(8'h30);
		chk(rv === 32'h0, "control after reset");
		tally_and_finish();
	end
endmodule
